// ### hw/sgss_top.sv
// Gain set selector with AHB-Lite register slave
// Overview of operation
// - Hold three gains per alternate set
// - Source one plus request applies alternate gains
// - Report set one active on status one
// - Report set two active on status five
// - Polarity 0: above thresholds selects sets
// - Polarity 0, threshold two zero: no set two
// - Polarity 0, threshold two lower: no set one
// - Polarity 1: two, one, base by speed
// - Polarity 1, threshold two zero: no set two
// - Polarity 1, threshold two higher: no set one
// - Option 1: jump on entry, filter return
// - Option 2: filter entry, jump on return
// - Option encoding 0 all, 1, 2
// - Lag filter per set time constant
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module sgss_top
    import sgss_pkg::*;
(
    input  wire logic        hclk,        // Control-cycle clock
    input  wire logic        hresetn,     // Async reset, active low
    input  wire logic        hsel,        // Slave select
    input  wire logic [31:0] haddr,       // Byte address
    input  wire logic [1:0]  htrans,      // Transfer type
    input  wire logic        hwrite,      // Write when high
    input  wire logic [2:0]  hsize,       // Transfer size
    input  wire logic [31:0] hwdata,      // Write data
    input  wire logic        hready,      // Bus ready in
    output logic      [31:0] hrdata,      // Read data
    output logic             hreadyout,   // Always ready
    output logic             hresp,       // Always OKAY
    output logic      [1:0]  active_set,  // Gain set now selected
    output logic      [15:0] speed_gain,  // Filtered speed-loop gain
    output logic      [15:0] integ_comp,  // Filtered speed integral compensation
    output logic      [15:0] model_gain   // Filtered model-loop gain
);
    import sgss_pkg::*;

    logic [15:0] ctrl_one_q;              // Control input word one
    logic [15:0] ctrl_five_q;             // Control input word five
    logic [15:0] config_q;                // Source, polarity, option, second select
    logic [15:0] thr_one_q;               // Threshold one
    logic [15:0] thr_two_q;               // Threshold two
    logic [15:0] ft_one_q;                // Filter time one (low four bits used)
    logic [15:0] ft_two_q;                // Filter time two
    logic [15:0] speed_q;                 // Signed motor speed from the loop
    logic [15:0] gain_q [0:SGSS_NUM_GAINS-1]; // Base, set one, set two gains
    logic        wr_pend_q;               // Write data phase pending
    logic [13:0] wr_idx_q;                // Index latched in address phase
    logic [31:0] hrdata_q;                // Read data register
    sgss_set_t   set_q;                   // Selected set
    sgss_set_t   set_d;                   // Next selected set
    sgss_set_t   prev_q;                  // Set last entered (for time constant)
    logic [15:0] abs_speed;               // Absolute speed
    logic [3:0]  src;                     // Gain selection source
    logic        pol;                     // Condition polarity
    logic [1:0]  fdo;                     // Filter disable option
    logic [3:0]  sel2;                    // Second set selection
    logic        bypass;                  // Filter bypass this cycle
    logic [3:0]  shift;                   // Active time constant
    logic        addr_ok;                 // Address phase valid
    logic [13:0] a_idx;                   // Address index
    logic [15:0] rd_w;                    // Read mux
    logic [15:0] tgt [0:2];               // Targets per gain kind
    logic [15:0] flt [0:2];               // Filter outputs

    assign src  = config_q[SGSS_CFG_SRC_LSB +: 4];
    assign pol  = config_q[SGSS_CFG_POL_BIT];
    assign fdo  = config_q[SGSS_CFG_FDO_LSB +: 2];
    assign sel2 = config_q[SGSS_CFG_SEL2_LSB +: 4];
    // Two's complement magnitude; the most negative value saturates
    assign abs_speed = speed_q[15] ? ((speed_q == 16'h8000) ? 16'h7fff : 16'(-speed_q)) : speed_q;

    // AHB address decode, word index is byte address over four
    // Gated by hready so a transfer stalled elsewhere is not taken twice
    assign addr_ok = hsel && hready && (htrans == SGSS_HTRANS_NONSEQ || htrans == SGSS_HTRANS_SEQ);
    assign a_idx   = haddr[15:2];

    // Zero wait states, so the slave never stalls the master
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    // Set selection from speed or from controller request bits
    // With second select signal or same, set two is tried first, so it wins while both requests stand
    always_comb begin
        set_d = SGSS_SET_BASE;
        case (src)
            SGSS_SRC_SIGNAL: begin
                // Controller keeps the request bits
                if (sel2 == SGSS_SEL2_SIGNAL || sel2 == SGSS_SEL2_SAME) begin
                    if (ctrl_five_q[SGSS_REQ_BIT]) begin
                        set_d = SGSS_SET_TWO;
                    end else if (ctrl_one_q[SGSS_REQ_BIT]) begin
                        set_d = SGSS_SET_ONE;
                    end
                end else if (ctrl_one_q[SGSS_REQ_BIT]) begin
                    set_d = SGSS_SET_ONE;
                end
            end
            SGSS_SRC_SPEED: begin
                if (sel2 != SGSS_SEL2_SAME || thr_two_q == 16'h0000) begin
                    // Only set one is reachable
                    if (!pol && abs_speed > thr_one_q) begin
                        set_d = SGSS_SET_ONE;
                    end else if (pol && abs_speed < thr_one_q) begin
                        set_d = SGSS_SET_ONE;
                    end
                end else if (!pol) begin
                    if (thr_two_q >= thr_one_q) begin
                        if (abs_speed > thr_two_q) begin
                            set_d = SGSS_SET_TWO;
                        end else if (abs_speed > thr_one_q) begin
                            set_d = SGSS_SET_ONE;
                        end
                    end else if (abs_speed > thr_two_q) begin
                        set_d = SGSS_SET_TWO;
                    end
                end else begin
                    if (thr_two_q <= thr_one_q) begin
                        if (abs_speed < thr_two_q) begin
                            set_d = SGSS_SET_TWO;
                        end else if (abs_speed < thr_one_q) begin
                            set_d = SGSS_SET_ONE;
                        end
                    end else if (abs_speed < thr_two_q) begin
                        set_d = SGSS_SET_TWO;
                    end
                end
            end
            default: begin
                set_d = SGSS_SET_BASE;
            end
        endcase
    end

    // Selected set register, base after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            set_q <= SGSS_SET_BASE;
        end else begin
            set_q <= set_d;
        end
    end

    // Remember the alternate set last entered, so its time constant governs the return
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_q <= SGSS_SET_ONE;
        end else if (set_q != SGSS_SET_BASE) begin
            prev_q <= set_q;
        end
    end

    // Bypass decision from the selected set, held for every cycle the set stays in the bypassed class
    // Taken from the registered set, so gains never follow a half-decoded choice
    always_comb begin
        bypass = 1'b0;
        case (fdo)
            SGSS_FDO_ALL: begin
                bypass = 1'b0;
            end
            SGSS_FDO_SWITCH: begin
                // Jump into alternate sets, filter the way back
                bypass = (set_q != SGSS_SET_BASE);
            end
            SGSS_FDO_RETURN: begin
                // Filter into alternate sets, jump back to base
                bypass = (set_q == SGSS_SET_BASE);
            end
            default: begin
                bypass = 1'b0;
            end
        endcase
    end

    // Time constant of the set being entered or left
    always_comb begin
        case (set_q)
            SGSS_SET_TWO: shift = ft_two_q[3:0];
            SGSS_SET_ONE: shift = ft_one_q[3:0];
            default:      shift = (prev_q == SGSS_SET_TWO) ? ft_two_q[3:0] : ft_one_q[3:0];
        endcase
    end

    // One filter per gain kind, target picked from the active set
    // Shared time constant and bypass keep the three gains moving in step
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_gain
            always_comb begin
                case (set_q)
                    SGSS_SET_ONE: tgt[g] = gain_q[3 + g];
                    SGSS_SET_TWO: tgt[g] = gain_q[6 + g];
                    default:      tgt[g] = gain_q[g];
                endcase
            end
            sgss_lag_filter u_flt (
                .hclk    (hclk),
                .hresetn (hresetn),
                .target  (tgt[g]),
                .shift   (shift),
                .bypass  (bypass),
                .value_q (flt[g])
            );
        end
    endgenerate

    assign speed_gain = flt[0];
    assign integ_comp = flt[1];
    assign model_gain = flt[2];
    assign active_set = set_q;

    // Address phase capture for writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 14'h0000;
        end else begin
            wr_pend_q <= addr_ok && hwrite && hsize == SGSS_HSIZE_WORD;
            wr_idx_q  <= a_idx;
        end
    end

    // Register writes in the data phase
    // Status indices fall to the default branch, so they stay read-only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_one_q  <= SGSS_RST_WORD;
            ctrl_five_q <= SGSS_RST_WORD;
            config_q    <= SGSS_RST_CONFIG;
            thr_one_q   <= SGSS_RST_WORD;
            thr_two_q   <= SGSS_RST_WORD;
            ft_one_q    <= SGSS_RST_FT;
            ft_two_q    <= SGSS_RST_FT;
            speed_q     <= SGSS_RST_WORD;
            for (int i = 0; i < SGSS_NUM_GAINS; i++) begin
                gain_q[i] <= SGSS_RST_WORD;
            end
        end else if (wr_pend_q) begin
            case (wr_idx_q)
                SGSS_IDX_CTRL_ONE[13:0]:  ctrl_one_q  <= hwdata[15:0];
                SGSS_IDX_CTRL_FIVE[13:0]: ctrl_five_q <= hwdata[15:0];
                SGSS_IDX_CONFIG[13:0]:    config_q    <= hwdata[15:0];
                SGSS_IDX_THR_ONE[13:0]:   thr_one_q   <= hwdata[15:0];
                SGSS_IDX_THR_TWO[13:0]:   thr_two_q   <= hwdata[15:0];
                SGSS_IDX_FT_ONE[13:0]:    ft_one_q    <= hwdata[15:0];
                SGSS_IDX_FT_TWO[13:0]:    ft_two_q    <= hwdata[15:0];
                SGSS_IDX_SPEED[13:0]:     speed_q     <= hwdata[15:0];
                default: begin
                    // Gain table, unmapped indices are ignored
                    for (int i = 0; i < SGSS_NUM_GAINS; i++) begin
                        if (wr_idx_q == 14'(SGSS_IDX_GAIN_BASE + 16'(i))) begin
                            gain_q[i] <= hwdata[15:0];
                        end
                    end
                end
            endcase
        end
    end

    // Read mux, status words show the live set
    always_comb begin
        rd_w = 16'h0000;
        case (a_idx)
            SGSS_IDX_CTRL_ONE[13:0]:  rd_w = ctrl_one_q;
            SGSS_IDX_CTRL_FIVE[13:0]: rd_w = ctrl_five_q;
            SGSS_IDX_STAT_ONE[13:0]:  rd_w[SGSS_REQ_BIT] = (set_q == SGSS_SET_ONE);
            SGSS_IDX_STAT_FIVE[13:0]: rd_w[SGSS_REQ_BIT] = (set_q == SGSS_SET_TWO);
            SGSS_IDX_CONFIG[13:0]:    rd_w = config_q;
            SGSS_IDX_THR_ONE[13:0]:   rd_w = thr_one_q;
            SGSS_IDX_THR_TWO[13:0]:   rd_w = thr_two_q;
            SGSS_IDX_FT_ONE[13:0]:    rd_w = ft_one_q;
            SGSS_IDX_FT_TWO[13:0]:    rd_w = ft_two_q;
            SGSS_IDX_SPEED[13:0]:     rd_w = speed_q;
            default: begin
                for (int i = 0; i < SGSS_NUM_GAINS; i++) begin
                    if (a_idx == 14'(SGSS_IDX_GAIN_BASE + 16'(i))) begin
                        rd_w = gain_q[i];
                    end
                end
            end
        endcase
    end

    // Read data captured at address phase, shown in data phase
    // A read right behind a write to the same register still sees the old value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata_q <= {16'h0000, rd_w};
        end
    end
endmodule

// ### include/sgss_pkg.sv
// Package of constants for the servo gain set selector
package sgss_pkg;
    // Register word indices (printed offsets are not all word aligned: index times four)
    localparam logic [15:0] SGSS_IDX_CTRL_ONE   = 16'h2d01;
    localparam logic [15:0] SGSS_IDX_CTRL_FIVE  = 16'h2d05;
    localparam logic [15:0] SGSS_IDX_STAT_ONE   = 16'h2d11;
    localparam logic [15:0] SGSS_IDX_STAT_FIVE  = 16'h2d15;
    localparam logic [15:0] SGSS_IDX_CONFIG     = 16'h2d20;
    localparam logic [15:0] SGSS_IDX_THR_ONE    = 16'h2d21;
    localparam logic [15:0] SGSS_IDX_THR_TWO    = 16'h2d22;
    localparam logic [15:0] SGSS_IDX_FT_ONE     = 16'h2d23;
    localparam logic [15:0] SGSS_IDX_FT_TWO     = 16'h2d24;
    localparam logic [15:0] SGSS_IDX_SPEED      = 16'h2d25;
    localparam logic [15:0] SGSS_IDX_GAIN_BASE  = 16'h2d30;
    localparam int          SGSS_NUM_GAINS      = 9;
    // Field positions
    localparam int          SGSS_REQ_BIT        = 4;
    localparam int          SGSS_CFG_SRC_LSB    = 0;
    localparam int          SGSS_CFG_POL_BIT    = 4;
    localparam int          SGSS_CFG_FDO_LSB    = 8;
    localparam int          SGSS_CFG_SEL2_LSB   = 12;
    // Encodings
    localparam logic [3:0]  SGSS_SRC_SIGNAL     = 4'h1;
    localparam logic [3:0]  SGSS_SRC_SPEED      = 4'h4;
    localparam logic [3:0]  SGSS_SEL2_SIGNAL    = 4'h1;
    localparam logic [3:0]  SGSS_SEL2_SAME      = 4'h2;
    localparam logic [1:0]  SGSS_FDO_ALL        = 2'h0;
    localparam logic [1:0]  SGSS_FDO_SWITCH     = 2'h1;
    localparam logic [1:0]  SGSS_FDO_RETURN     = 2'h2;
    // Reset values
    localparam logic [15:0] SGSS_RST_CONFIG     = 16'h0000;
    localparam logic [15:0] SGSS_RST_WORD       = 16'h0000;
    localparam logic [15:0] SGSS_RST_FT         = 16'h0004;
    // AHB encodings
    localparam logic [1:0]  SGSS_HTRANS_NONSEQ  = 2'h2;
    localparam logic [1:0]  SGSS_HTRANS_SEQ     = 2'h3;
    localparam logic [2:0]  SGSS_HSIZE_WORD     = 3'h2;
    // Gain set encoding
    typedef enum logic [1:0] {
        SGSS_SET_BASE = 2'b00,
        SGSS_SET_ONE  = 2'b01,
        SGSS_SET_TWO  = 2'b10
    } sgss_set_t;
endpackage

// ### hw/sgss_lag_filter.sv
// First-order lag filter that moves one gain toward its target
`timescale 1ns/1ps
module sgss_lag_filter (
    input  wire logic        hclk,       // Control-cycle clock
    input  wire logic        hresetn,    // Async reset, active low
    input  wire logic [15:0] target,     // Gain the set asks for
    input  wire logic [3:0]  shift,      // Time constant as a power of two
    input  wire logic        bypass,     // Jump straight to target
    output logic      [15:0] value_q     // Smoothed gain
);
    logic [31:0] acc_q;                  // Fixed point value, 16 fractional bits
    logic [31:0] tgt_w;                  // Target in fixed point
    logic [31:0] step_w;                 // Signed step toward target

    assign tgt_w  = {target, 16'h0000};
    // Arithmetic shift keeps the sign; small steps never stall at zero
    assign step_w = 32'($signed(tgt_w - acc_q) >>> shift);

    // Lag update, or a jump when bypassed or when the residue is tiny
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_q <= 32'h0000_0000;
        end else if (bypass || step_w == 32'h0000_0000) begin
            acc_q <= tgt_w;
        end else begin
            acc_q <= acc_q + step_w;
        end
    end

    assign value_q = acc_q[31:16];
endmodule

// ### bench/sgss_chk.sv
// Port checker for the gain set selector
`timescale 1ns/1ps
module sgss_chk
    import sgss_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [1:0]  active_set
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic rd_go; // Read address phase taken
    logic wr_go; // Write address phase taken
    assign rd_go = hsel && hready && htrans[1] && !hwrite;
    assign wr_go = hsel && hready && htrans[1] && hwrite;
    // Zero-wait slave, never an error
    bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
    // Registers are 16 bits wide, upper half reads zero
    rdata_upper_a: assert property (hrdata[31:16] == 16'h0000) else $error("upper read half not zero");
    // Only three sets exist
    set_legal_a: assert property (active_set != 2'b11) else $error("illegal set code");
    // Leaving reset starts on the base set
    reset_base_a: assert property ($rose(hresetn) |-> active_set == SGSS_SET_BASE) else $error("not base after reset");
    // Set changes three edges after a write address phase: data phase, register, set
    set_cause_a: assert property (!$stable(active_set) |-> $past(wr_go, 3)) else $error("set changed without write");
    // Status words mirror the selected set
    stat_one_a: assert property (rd_go && haddr[15:2] == SGSS_IDX_STAT_ONE[13:0] |=>
        hrdata[15:0] == (($past(active_set) == SGSS_SET_ONE) ? 16'h0010 : 16'h0000)) else $error("status one wrong");
    stat_five_a: assert property (rd_go && haddr[15:2] == SGSS_IDX_STAT_FIVE[13:0] |=>
        hrdata[15:0] == (($past(active_set) == SGSS_SET_TWO) ? 16'h0010 : 16'h0000)) else $error("status five wrong");
    // Read data stands until the next read
    rdata_hold_a: assert property (!rd_go |=> $stable(hrdata)) else $error("read data moved");
endmodule
bind sgss_top sgss_chk chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .active_set(active_set));

// ### bench/sgss_ctl_model.sv
// Motion controller model: bus master writing control words
`timescale 1ns/1ps
module sgss_ctl_model
    import sgss_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata
);
    // Bus idle at time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = SGSS_HSIZE_WORD;
        hwdata = 32'h0;
    end
    // One single transfer; call just after a rising edge
    task automatic xfer(input logic [15:0] idx, input logic wr, input logic [31:0] wd,
                        input logic [2:0] sz, output logic [31:0] rd, output logic late);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {16'h0, idx[13:0], 2'b00};
        htrans <= SGSS_HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= sz;
        // Address phase held until ready is seen
        do begin @(posedge hclk); n++; end while (!hready && n < 64);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        // Data phase held until ready again
        do begin @(posedge hclk); n++; end while (!hready && n < 128);
        rd = hrdata;
        late = (n >= 64);
        // Released data lines must not look valid
        hwdata <= ~wd;
    endtask
endmodule

// ### bench/tb_top.sv
// Testbench for the gain set selector
`timescale 1ns/1ps
module tb_top;
    import sgss_pkg::*;
    logic        hclk;        // Control-cycle clock
    logic        hresetn;     // Reset, active low
    logic        hsel;        // Select from controller
    logic [31:0] haddr;       // Byte address
    logic [1:0]  htrans;      // Transfer type
    logic        hwrite;      // Write strobe
    logic [2:0]  hsize;       // Transfer size
    logic [31:0] hwdata;      // Write data
    logic [31:0] hrdata;      // Read data
    logic        hreadyout;   // Ready, fed back as hready
    logic        hresp;       // Response
    logic [1:0]  active_set;  // Selected set
    logic [15:0] speed_gain;  // Filtered gains
    logic [15:0] integ_comp;
    logic [15:0] model_gain;
    int          err_total;   // Mismatches
    int          comparisons; // Checks made
    int          settle_n;    // Cycles the last gain settling took
    sgss_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .active_set(active_set), .speed_gain(speed_gain),
        .integ_comp(integ_comp), .model_gain(model_gain));
    sgss_ctl_model ctl_u (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    // 100 MHz clock
    initial hclk = 1'b0;
    always #5 hclk = ~hclk;
    // Verdict and end of run
    task automatic stop_test;
        if (err_total == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Bus access with hang guard
    task automatic acc(input logic [15:0] idx, input logic wr, input logic [15:0] d, input logic [2:0] sz,
                       output logic [31:0] rd);
        logic late;
        ctl_u.xfer(idx, wr, {16'h0, d}, sz, rd, late);
        if (late) begin
            err_total++;
            stop_test();
        end
    endtask
    task automatic wr(input logic [15:0] idx, input logic [15:0] d);
        logic [31:0] rd;
        acc(idx, 1'b1, d, SGSS_HSIZE_WORD, rd);
    endtask
    task automatic rdc(input logic [15:0] idx, input logic [15:0] exp, input string what);
        logic [31:0] rd;
        acc(idx, 1'b0, 16'h0, SGSS_HSIZE_WORD, rd);
        check(what, {16'h0, exp}, rd);
    endtask
    // Waits for the set; stale value skipped first
    task automatic wait_set(input sgss_set_t exp);
        int n;
        repeat (2) @(posedge hclk);
        for (n = 0; n < 8 && active_set !== exp; n++) @(posedge hclk);
        check("active_set", 32'(exp), 32'(active_set));
    endtask
    // Gains of set g: jumped (exact) or still filtering, then settled
    task automatic gains(input int g, input bit exact);
        logic [15:0] t;
        int n;
        t = 16'(g + 1) << 12;
        repeat (2) @(posedge hclk);
        if (exact) check("gains", {t, t + 16'h2}, {speed_gain, model_gain});
        else check("filtering", 32'h1, 32'(speed_gain !== t));
        for (n = 0; n < 4000 && {speed_gain, integ_comp, model_gain} !== {t, t + 16'h1, t + 16'h2}; n++)
            @(posedge hclk);
        check("settled", 32'h0, 32'(n >= 4000));
        settle_n = n;
        if (n >= 4000) stop_test();
    endtask
    function automatic logic [15:0] cfg(input logic pol, input logic [1:0] fdo, input logic [3:0] src,
                                        input logic [3:0] sel2);
        return {sel2, 2'b00, fdo, 3'b000, pol, src};
    endfunction
    // Speed case: thresholds and speed, then expected set
    task automatic spd(input logic pol, input logic [15:0] t1, input logic [15:0] t2, input logic [15:0] s,
                       input sgss_set_t e);
        wr(SGSS_IDX_CONFIG, cfg(pol, SGSS_FDO_SWITCH, SGSS_SRC_SPEED, SGSS_SEL2_SAME));
        wr(SGSS_IDX_THR_ONE, t1);
        wr(SGSS_IDX_THR_TWO, t2);
        wr(SGSS_IDX_SPEED, s);
        wait_set(e);
    endtask
    // Main sequence
    initial begin
        logic [31:0] rd;
        err_total = 0;
        comparisons = 0;
        hresetn = 1'b0;
        repeat (20) @(posedge hclk);
        check("reset outputs", 32'h0, {14'h0, active_set, speed_gain});
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(SGSS_IDX_STAT_ONE, 16'h0, "status one");
        rdc(SGSS_IDX_STAT_FIVE, 16'h0, "status five");
        rdc(SGSS_IDX_FT_ONE, SGSS_RST_FT, "filter time one");
        rdc(SGSS_IDX_CONFIG, SGSS_RST_CONFIG, "config");
        rdc(16'h2d00, 16'h0, "unmapped");
        wr(SGSS_IDX_STAT_ONE, 16'hffff);
        rdc(SGSS_IDX_STAT_ONE, 16'h0, "status read-only");
        // Request ignored while the source is base only
        wr(SGSS_IDX_CTRL_ONE, 16'h0010);
        rdc(SGSS_IDX_CTRL_ONE, 16'h0010, "control one");
        wait_set(SGSS_SET_BASE);
        wr(SGSS_IDX_CTRL_ONE, 16'h0000);
        for (int i = 0; i < SGSS_NUM_GAINS; i++) wr(SGSS_IDX_GAIN_BASE + 16'(i), 16'((i / 3 + 1) << 12) + 16'(i % 3));
        rdc(SGSS_IDX_GAIN_BASE + 16'h4, 16'h2001, "set one gain");
        // Byte write must be dropped
        acc(SGSS_IDX_CONFIG, 1'b1, 16'h1101, 3'h0, rd);
        rdc(SGSS_IDX_CONFIG, 16'h0, "byte write");
        wr(SGSS_IDX_CONFIG, cfg(1'b0, SGSS_FDO_SWITCH, SGSS_SRC_SIGNAL, SGSS_SEL2_SIGNAL));
        wr(SGSS_IDX_CTRL_ONE, 16'h0010);
        wait_set(SGSS_SET_ONE);
        rdc(SGSS_IDX_STAT_ONE, 16'h0010, "status one");
        gains(1, 1'b1);
        wr(SGSS_IDX_CTRL_FIVE, 16'h0010);
        wait_set(SGSS_SET_TWO);
        rdc(SGSS_IDX_STAT_FIVE, 16'h0010, "status five");
        rdc(SGSS_IDX_STAT_ONE, 16'h0, "status one");
        gains(2, 1'b1);
        wr(SGSS_IDX_CTRL_ONE, 16'h0000);
        wr(SGSS_IDX_CTRL_FIVE, 16'h0000);
        wait_set(SGSS_SET_BASE);
        gains(0, 1'b0);
        wr(SGSS_IDX_CONFIG, cfg(1'b0, SGSS_FDO_RETURN, SGSS_SRC_SIGNAL, SGSS_SEL2_SIGNAL));
        wr(SGSS_IDX_CTRL_FIVE, 16'h0010);
        wait_set(SGSS_SET_TWO);
        gains(2, 1'b0);
        check("slow filter", 32'h1, 32'(settle_n > 100));
        wr(SGSS_IDX_CTRL_FIVE, 16'h0000);
        wait_set(SGSS_SET_BASE);
        gains(0, 1'b1);
        wr(SGSS_IDX_FT_ONE, 16'h0001);
        wr(SGSS_IDX_CONFIG, cfg(1'b0, SGSS_FDO_ALL, SGSS_SRC_SIGNAL, SGSS_SEL2_SIGNAL));
        wr(SGSS_IDX_CTRL_ONE, 16'h0010);
        wait_set(SGSS_SET_ONE);
        gains(1, 1'b0);
        check("fast filter", 32'h1, 32'(settle_n < 40));
        wr(SGSS_IDX_CTRL_ONE, 16'h0000);
        wait_set(SGSS_SET_BASE);
        gains(0, 1'b0);
        // Speed-driven selection, both polarities, sign of speed ignored
        spd(1'b0, 16'd100, 16'd200, 16'd50, SGSS_SET_BASE);
        spd(1'b0, 16'd100, 16'd200, 16'd150, SGSS_SET_ONE);
        spd(1'b0, 16'd100, 16'd200, -16'sd250, SGSS_SET_TWO);
        spd(1'b0, 16'd100, 16'd200, 16'd100, SGSS_SET_BASE);
        spd(1'b0, 16'd100, 16'd0, 16'd500, SGSS_SET_ONE);
        spd(1'b0, 16'd200, 16'd100, 16'd150, SGSS_SET_TWO);
        spd(1'b0, 16'd200, 16'd100, 16'd300, SGSS_SET_TWO);
        spd(1'b1, 16'd200, 16'd100, 16'd50, SGSS_SET_TWO);
        spd(1'b1, 16'd200, 16'd100, -16'sd150, SGSS_SET_ONE);
        spd(1'b1, 16'd200, 16'd100, 16'd200, SGSS_SET_BASE);
        spd(1'b1, 16'd200, 16'd0, 16'd50, SGSS_SET_ONE);
        spd(1'b1, 16'd200, 16'd0, 16'd300, SGSS_SET_BASE);
        spd(1'b1, 16'd100, 16'd200, 16'd50, SGSS_SET_TWO);
        spd(1'b1, 16'd100, 16'd200, 16'd150, SGSS_SET_TWO);
        spd(1'b1, 16'd100, 16'd200, 16'd300, SGSS_SET_BASE);
        spd(1'b0, 16'd100, 16'd200, 16'd150, SGSS_SET_ONE);
        // Second reset in mid-run returns to base
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        check("reset set", 32'h0, 32'(active_set));
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        stop_test();
    end
endmodule
